// file: scrc_core.sv
// Purpose: Seconds-counter timekeeping core with serial bus slave and supply supervisor.
// Assumes: All pin inputs asynchronous to sys_clk; sdaIn/sclIn are wire levels.
// Notes:   Open-drain pins: Oe high pulls the line low, Out is held at zero.
// Summary of operation
// - A 32-bit counter advances once per second of oscillator time.
// - Reset output is driven active while supply is at or below trip.
// - After supply returns, reset stays active for 250 ms.
// - Stop bit set during the fail adds oscillator start-up time to hold.
// - Writes are START, slave address, pointer, then bytes until STOP; reads send no pointer byte.
// - Counter bytes sit at pointers 00h to 03h, readable and writable.
// - Pointer increments per byte and wraps from 05h to 00h.
// - While supply is failed, all serial register access is refused.
// - Control bit 7 is an active-low oscillator enable for backup supply.
// - On backup, stop bit 0 runs oscillator, 1 stops it into standby.
// - On main supply oscillator runs; counting only while stop bit is 0.
// - Charger enabled only when unlock key bits 7-4 equal 1010.
// - Charger configuration powers up disabled.
// - Resistor field 01-11 picks a resistor; 00 disables charger.
// - Slave address 1101000, direction bit 1 reads; matching address is acked.
// - Read without pointer write starts at the pointer left last time.

`timescale 1ns/10ps

module scrc_core
   import scrc_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = RST_HOLD_CYC,
   parameter int unsigned START_CYCLES = OSC_START_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic oscClkIn,
   input wire logic supplyLow,
   input wire logic onBackup,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   output logic resetOut_n,
   output logic resetOe,
   output logic oscRun,
   output logic standby,
   output scrc_charge_t charge
);

   // Two-flop synchronisers for every pin input
   logic [4:0] syncA_q;
   logic [4:0] syncB_q;
   logic oscPrev_q;
   logic sclPrev_q;
   logic sdaPrev_q;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         syncA_q <= 5'h1F;
         syncB_q <= 5'h1F;
         oscPrev_q <= 1'b1;
         sclPrev_q <= 1'b1;
         sdaPrev_q <= 1'b1;
      end else if (clkEn) begin
         syncA_q <= {oscClkIn, supplyLow, onBackup, sclIn, sdaIn};
         syncB_q <= syncA_q;
         oscPrev_q <= syncB_q[4];
         sclPrev_q <= syncB_q[1];
         sdaPrev_q <= syncB_q[0];
      end
   end

   logic oscS;
   logic failS;
   logic backupS;
   logic sclS;
   logic sdaS;
   assign {oscS, failS, backupS, sclS, sdaS} = syncB_q;

   logic oscRise;
   logic sclRise;
   logic sclFall;
   logic startEv;
   logic stopEv;
   assign oscRise = oscS & ~oscPrev_q;
   assign sclRise = sclS & ~sclPrev_q;
   assign sclFall = ~sclS & sclPrev_q;
   assign startEv = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
   assign stopEv = sclS & sclPrev_q & ~sdaPrev_q & sdaS;

   // Stored state
   logic [31:0] count_q;
   logic [7:0] snap_q [4];
   logic oscStop_q;
   logic [7:0] chargeCfg_q;
   logic dirty_q;

   // Serial bus slave state
   scrc_bus_state_t busSt_q;
   scrc_phase_t phase_q;
   logic [3:0] bitCnt_q;
   logic [7:0] shift_q;
   logic [7:0] txShift_q;
   logic [7:0] ptr_q;
   logic readDir_q;
   logic nack_q;
   logic sdaLow_q;

   function automatic logic [7:0] nextPtr(input logic [7:0] p);
      if (p >= REG_LAST) begin
         nextPtr = REG_COUNT_A;
      end else begin
         nextPtr = p + 8'h01;
      end
   endfunction : nextPtr

   function automatic logic [7:0] readReg(input logic [7:0] p);
      readReg = 8'h00;
      if (p == REG_COUNT_A) begin
         readReg = snap_q[0];
      end else if (p == REG_COUNT_B) begin
         readReg = snap_q[1];
      end else if (p == REG_COUNT_C) begin
         readReg = snap_q[2];
      end else if (p == REG_COUNT_D) begin
         readReg = snap_q[3];
      end else if (p == REG_OSC_CTRL) begin
         readReg = {oscStop_q, 7'h00};
      end else if (p == REG_CHARGE_CFG) begin
         readReg = chargeCfg_q;
      end
   endfunction : readReg

   // A function result cannot be part-selected, so the byte to send is a named net
   logic [7:0] rdVal;
   assign rdVal = readReg(ptr_q);

   logic byteDone;
   logic addrHit;
   logic wrStrobe;
   logic commit;
   assign byteDone = (busSt_q == BS_RECV) && sclFall && (bitCnt_q == 4'h8);
   assign addrHit = byteDone && (phase_q == PH_ADDR) && (shift_q[7:1] == DEV_ADDR);
   assign wrStrobe = byteDone && (phase_q == PH_DATA);
   // A repeated START also closes a write, so the counter never loads half a burst
   assign commit = (startEv || stopEv) && dirty_q && !failS;

   // Bus protocol engine
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         busSt_q <= BS_IDLE;
         phase_q <= PH_ADDR;
         bitCnt_q <= 4'h0;
         shift_q <= 8'h00;
         txShift_q <= 8'h00;
         ptr_q <= REG_COUNT_A;
         readDir_q <= 1'b0;
         nack_q <= 1'b0;
         sdaLow_q <= 1'b0;
      end else if (clkEn) begin
         if (failS) begin
            busSt_q <= BS_IDLE;
            sdaLow_q <= 1'b0;
         end else if (startEv) begin
            busSt_q <= BS_RECV;
            phase_q <= PH_ADDR;
            bitCnt_q <= 4'h0;
            sdaLow_q <= 1'b0;
         end else if (stopEv) begin
            busSt_q <= BS_IDLE;
            sdaLow_q <= 1'b0;
         end else begin
            case (busSt_q)
               BS_RECV: begin
                  if (sclRise && bitCnt_q != 4'h8) begin
                     shift_q <= {shift_q[6:0], sdaS};
                     bitCnt_q <= bitCnt_q + 4'h1;
                  end else if (byteDone) begin
                     if (phase_q == PH_ADDR) begin
                        if (addrHit) begin
                           readDir_q <= shift_q[0];
                           phase_q <= PH_PTR;
                           busSt_q <= BS_ACK;
                           sdaLow_q <= 1'b1;
                        end else begin
                           busSt_q <= BS_IDLE;
                        end
                     end else if (phase_q == PH_PTR) begin
                        ptr_q <= shift_q;
                        phase_q <= PH_DATA;
                        busSt_q <= BS_ACK;
                        sdaLow_q <= 1'b1;
                     end else begin
                        ptr_q <= nextPtr(ptr_q);
                        busSt_q <= BS_ACK;
                        sdaLow_q <= 1'b1;
                     end
                  end
               end
               BS_ACK: begin
                  if (sclFall) begin
                     if (readDir_q) begin
                        // Read starts wherever the pointer was left
                        txShift_q <= {rdVal[6:0], 1'b0};
                        sdaLow_q <= ~rdVal[7];
                        bitCnt_q <= 4'h1;
                        busSt_q <= BS_SEND;
                     end else begin
                        sdaLow_q <= 1'b0;
                        bitCnt_q <= 4'h0;
                        busSt_q <= BS_RECV;
                     end
                  end
               end
               BS_SEND: begin
                  if (sclFall) begin
                     if (bitCnt_q == 4'h8) begin
                        sdaLow_q <= 1'b0;
                        ptr_q <= nextPtr(ptr_q);
                        busSt_q <= BS_MACK;
                     end else begin
                        sdaLow_q <= ~txShift_q[7];
                        txShift_q <= {txShift_q[6:0], 1'b0};
                        bitCnt_q <= bitCnt_q + 4'h1;
                     end
                  end
               end
               BS_MACK: begin
                  if (sclRise) begin
                     nack_q <= sdaS;
                  end else if (sclFall) begin
                     if (nack_q) begin
                        busSt_q <= BS_IDLE;
                     end else begin
                        txShift_q <= {rdVal[6:0], 1'b0};
                        sdaLow_q <= ~rdVal[7];
                        bitCnt_q <= 4'h1;
                        busSt_q <= BS_SEND;
                     end
                  end
               end
               default: begin
                  sdaLow_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // Counter bytes: snapshot on address match, edited in place by writes
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : gSnap
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               snap_q[g] <= 8'h00;
            end else if (clkEn) begin
               if (addrHit) begin
                  snap_q[g] <= count_q[8 * g +: 8];
               end else if (wrStrobe && ptr_q == 8'(g)) begin
                  snap_q[g] <= shift_q;
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dirty_q <= 1'b0;
      end else if (clkEn) begin
         if (commit || failS) begin
            dirty_q <= 1'b0;
         end else if (wrStrobe && ptr_q <= REG_COUNT_D) begin
            dirty_q <= 1'b1;
         end
      end
   end

   // Control and charger configuration
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         oscStop_q <= OSC_STOP_RST;
         chargeCfg_q <= CHARGE_CFG_RST;
      end else if (clkEn) begin
         if (wrStrobe && ptr_q == REG_OSC_CTRL) begin
            oscStop_q <= shift_q[OSC_STOP_BIT];
         end
         if (wrStrobe && ptr_q == REG_CHARGE_CFG) begin
            chargeCfg_q <= shift_q;
         end
      end
   end

   logic [3:0] keyF;
   logic [1:0] diodeF;
   logic [1:0] resF;
   assign keyF = chargeCfg_q[KEY_MSB:KEY_LSB];
   assign diodeF = chargeCfg_q[DIODE_MSB:DIODE_LSB];
   assign resF = chargeCfg_q[RES_MSB:RES_LSB];

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         charge <= '0;
      end else if (clkEn) begin
         charge.enable <= (keyF == CHARGER_KEY)
            && (diodeF == DIODE_NONE || diodeF == DIODE_IN)
            && (resF != RES_NONE);
         charge.diodeIn <= (diodeF == DIODE_IN);
         charge.resistor <= resF;
      end
   end

   // Oscillator gating
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         oscRun <= 1'b1;
         standby <= 1'b0;
      end else if (clkEn) begin
         oscRun <= !backupS || !oscStop_q;
         standby <= backupS && oscStop_q;
      end
   end

   // Seconds prescaler; stopping it keeps the partial second for later
   logic [14:0] presc_q;
   logic tick;
   logic countEn;
   assign countEn = !oscStop_q;
   assign tick = countEn && oscRise && (presc_q == 15'(OSC_DIV - 1));

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         presc_q <= 15'h0000;
      end else if (clkEn) begin
         if (countEn && oscRise) begin
            presc_q <= presc_q + 15'h0001;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= COUNT_RST;
      end else if (clkEn) begin
         if (commit) begin
            // Software load wins over a coincident tick
            count_q <= {snap_q[3], snap_q[2], snap_q[1], snap_q[0]};
         end else if (tick) begin
            count_q <= count_q + 32'h0000_0001;
         end
      end
   end

   // Supply supervisor; power-on behaves like a supply return
   scrc_pwr_state_t pwrSt_q;
   logic [31:0] hold_q;
   logic stopInFail_q;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pwrSt_q <= PS_FAIL;
         hold_q <= 32'h0000_0000;
         stopInFail_q <= 1'b0;
      end else if (clkEn) begin
         case (pwrSt_q)
            PS_FAIL: begin
               if (oscStop_q) begin
                  stopInFail_q <= 1'b1;
               end
               if (!failS) begin
                  pwrSt_q <= PS_HOLD;
                  if (stopInFail_q || oscStop_q) begin
                     hold_q <= 32'(HOLD_CYCLES) + 32'(START_CYCLES);
                  end else begin
                     hold_q <= 32'(HOLD_CYCLES);
                  end
               end
            end
            PS_HOLD: begin
               if (failS) begin
                  pwrSt_q <= PS_FAIL;
               end else if (hold_q <= 32'h0000_0001) begin
                  pwrSt_q <= PS_OK;
                  stopInFail_q <= 1'b0;
               end else begin
                  hold_q <= hold_q - 32'h0000_0001;
               end
            end
            PS_OK: begin
               if (failS) begin
                  pwrSt_q <= PS_FAIL;
                  stopInFail_q <= oscStop_q;
               end
            end
            default: begin
               pwrSt_q <= PS_FAIL;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         resetOe <= 1'b1;
         resetOut_n <= 1'b0;
         sdaOe <= 1'b0;
         sdaOut <= 1'b0;
      end else if (clkEn) begin
         resetOe <= (pwrSt_q != PS_OK) && !(pwrSt_q == PS_HOLD && hold_q <= 32'h0000_0001);
         resetOut_n <= 1'b0;
         sdaOe <= sdaLow_q && !failS;
         sdaOut <= 1'b0;
      end
   end

endmodule : scrc_core

// file: scrc_pkg.sv
// Purpose: Shared constants and types for the seconds-counter timekeeping core.
// Assumes: 125 MHz system clock; 32.768 kHz oscillator sampled as a plain input.
// Notes:   Register pointer values, field positions, reset values and timing counts.

package scrc_pkg;

   // System clock rate
   localparam int unsigned SYS_CLK_KHZ = 125000;

   // Register pointer values
   localparam logic [7:0] REG_COUNT_A = 8'h00;
   localparam logic [7:0] REG_COUNT_B = 8'h01;
   localparam logic [7:0] REG_COUNT_C = 8'h02;
   localparam logic [7:0] REG_COUNT_D = 8'h03;
   localparam logic [7:0] REG_OSC_CTRL = 8'h04;
   localparam logic [7:0] REG_CHARGE_CFG = 8'h05;
   localparam logic [7:0] REG_LAST = REG_CHARGE_CFG;

   // Serial bus slave address
   localparam logic [6:0] DEV_ADDR = 7'h68;

   // Field positions
   localparam int OSC_STOP_BIT = 7;
   localparam int KEY_MSB = 7;
   localparam int KEY_LSB = 4;
   localparam int DIODE_MSB = 3;
   localparam int DIODE_LSB = 2;
   localparam int RES_MSB = 1;
   localparam int RES_LSB = 0;

   // Field codes
   localparam logic [3:0] CHARGER_KEY = 4'hA;
   localparam logic [1:0] DIODE_NONE = 2'h1;
   localparam logic [1:0] DIODE_IN = 2'h2;
   localparam logic [1:0] RES_NONE = 2'h0;

   // Reset values
   localparam logic OSC_STOP_RST = 1'b0;
   localparam logic [7:0] CHARGE_CFG_RST = 8'h00;
   localparam logic [31:0] COUNT_RST = 32'h0000_0000;

   // Oscillator division to one second
   localparam int unsigned OSC_DIV = 32768;

   // Supervisor timing
   localparam int unsigned RST_HOLD_MS = 250;
   localparam int unsigned RST_HOLD_CYC = RST_HOLD_MS * SYS_CLK_KHZ;
   localparam int unsigned OSC_START_MS = 500;
   localparam int unsigned OSC_START_CYC = OSC_START_MS * SYS_CLK_KHZ;

   typedef enum logic [4:0] {
      BS_IDLE = 5'b00001,
      BS_RECV = 5'b00010,
      BS_ACK = 5'b00100,
      BS_SEND = 5'b01000,
      BS_MACK = 5'b10000
   } scrc_bus_state_t;

   typedef enum logic [2:0] {
      PH_ADDR = 3'b001,
      PH_PTR = 3'b010,
      PH_DATA = 3'b100
   } scrc_phase_t;

   typedef enum logic [2:0] {
      PS_FAIL = 3'b001,
      PS_HOLD = 3'b010,
      PS_OK = 3'b100
   } scrc_pwr_state_t;

   typedef struct packed {
      logic enable;
      logic diodeIn;
      logic [1:0] resistor;
   } scrc_charge_t;

endpackage : scrc_pkg

// file: scrc_core_monitor.sv
// Purpose: Pin-level checks for the seconds-counter core.
// Assumes: One clock domain; clkEn held high.
// Notes: Hold bounds allow a few cycles for the input synchronisers.
`timescale 1ns/10ps

module scrc_core_monitor
   import scrc_pkg::*;
#(
   parameter int unsigned HOLD_CYCLES = RST_HOLD_CYC,
   parameter int unsigned START_CYCLES = OSC_START_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic supplyLow,
   input wire logic onBackup,
   input wire logic sclIn,
   input wire logic sdaOe,
   input wire logic resetOe,
   input wire logic oscRun,
   input wire logic standby,
   input wire scrc_charge_t charge
);
   logic [31:0] lowCnt_q;

   // Saturating, so a long quiet run never wraps into a false hold count
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lowCnt_q <= '0;
      end else if (supplyLow) begin
         lowCnt_q <= '0;
      end else if (lowCnt_q != 32'hFFFF_FFFF) begin
         lowCnt_q <= lowCnt_q + 32'h1;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   sequence s_fail_seen; supplyLow [*2]; endsequence
   // Two synchroniser stages plus the output register: the fourth sample is settled
   sequence s_main_supply; !onBackup [*4]; endsequence

   property p_fail_reset; s_fail_seen |-> ##[0:3] resetOe; endproperty
   a_fail_reset: assert property (p_fail_reset)
      else $error("reset not driven on supply fail");
   property p_hold_min; $fell(resetOe) |-> lowCnt_q >= HOLD_CYCLES; endproperty
   a_hold_min: assert property (p_hold_min)
      else $error("reset released early");
   property p_hold_max; lowCnt_q == HOLD_CYCLES + START_CYCLES + 8 |-> !resetOe; endproperty
   a_hold_max: assert property (p_hold_max)
      else $error("reset held too long");
   property p_bus_refused; supplyLow [*6] |-> !sdaOe; endproperty
   a_bus_refused: assert property (p_bus_refused)
      else $error("data line driven during supply fail");
   property p_sda_steady; sclIn [*5] ##0 !supplyLow |-> $stable(sdaOe); endproperty
   a_sda_steady: assert property (p_sda_steady)
      else $error("data line moved while clock high");
   property p_main_osc; s_main_supply |-> oscRun; endproperty
   a_main_osc: assert property (p_main_osc)
      else $error("oscillator off on main supply");
   property p_main_awake; s_main_supply |-> !standby; endproperty
   a_main_awake: assert property (p_main_awake)
      else $error("standby on main supply");
   property p_standby_stops; standby |-> !oscRun; endproperty
   a_standby_stops: assert property (p_standby_stops)
      else $error("oscillator runs in standby");
   property p_charge_res; charge.enable |-> charge.resistor != RES_NONE; endproperty
   a_charge_res: assert property (p_charge_res)
      else $error("charger on without resistor");
endmodule : scrc_core_monitor

bind scrc_core scrc_core_monitor #(.HOLD_CYCLES(HOLD_CYCLES), .START_CYCLES(START_CYCLES))
   i_scrc_core_monitor (.sys_clk(sys_clk), .rst_n(rst_n), .supplyLow(supplyLow),
   .onBackup(onBackup), .sclIn(sclIn), .sdaOe(sdaOe), .resetOe(resetOe), .oscRun(oscRun),
   .standby(standby), .charge(charge));

// file: scrc_bus_master.sv
// Purpose: Behavioural 2-wire bus master.
// Assumes: SDA is pulled up, so a released line reads high.
// Notes: qtr is a quarter bit; raise it to model a slow master.
`timescale 1ns/10ps

module scrc_bus_master (
   output logic scl,
   output logic sdaDrv,
   input wire logic sdaWire
);
   int qtr = 20;

   initial begin
      scl = 1'b1;
      sdaDrv = 1'b1;
   end

   // Data only moves while the clock is low
   task automatic xfer(input logic b, output logic r);
      sdaDrv = b;
      #qtr scl = 1'b1;
      #qtr r = sdaWire;
      #qtr scl = 1'b0;
      #qtr;
   endtask : xfer

   // Also a repeated START when the clock is low
   task automatic busStart();
      if (!scl) begin
         sdaDrv = 1'b1;
         #qtr scl = 1'b1;
         #qtr;
      end
      sdaDrv = 1'b0;
      #qtr scl = 1'b0;
      #qtr;
   endtask : busStart

   task automatic busStop();
      sdaDrv = 1'b0;
      #qtr scl = 1'b1;
      #qtr sdaDrv = 1'b1;
      #qtr;
   endtask : busStop

   task automatic wrByte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) xfer(d[i], r);
      xfer(1'b1, r);
      ack = !r;
   endtask : wrByte

   task automatic rdByte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         xfer(1'b1, r);
         d[i] = r;
      end
      xfer(last, r);
   endtask : rdByte
endmodule : scrc_bus_master

// file: scrc_core_bench.sv
// Purpose: Self-checking bench for the seconds-counter core.
// Assumes: Short hold counts; real oscillator rate, so no second elapses.
// Notes: A register model predicts every read byte and the charger outputs.
`timescale 1ns/10ps

module scrc_core_bench
   import scrc_pkg::*;
;
   localparam int unsigned HOLD = 200;
   localparam int unsigned START = 100;
   logic sys_clk, rst_n, clkEn, oscClkIn, supplyLow, onBackup, ack, en;
   logic sdaOut, sdaOe, resetOut_n, resetOe, oscRun, standby;
   wire logic sclIn, sdaIn, sdaDrv;
   scrc_charge_t charge;
   int n_fail = 0;
   int compares = 0;
   int ptr = 0;
   int mdl[6];
   logic [7:0] wq[$];
   logic [7:0] cfg;
   logic [31:0] rndState = 32'hACA7201C;
   logic [7:0] codes[12] = '{8'hA5, 8'hA6, 8'hA7, 8'hAB, 8'hA9, 8'hA4, 8'hA0, 8'hAC,
      8'hAD, 8'h5A, 8'hF5, 8'hB9};

   assign sdaIn = sdaDrv & (sdaOe ? sdaOut : 1'b1);

   scrc_core #(.HOLD_CYCLES(HOLD), .START_CYCLES(START)) i_scrc_core (
      .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .oscClkIn(oscClkIn),
      .supplyLow(supplyLow), .onBackup(onBackup), .sclIn(sclIn), .sdaIn(sdaIn),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .resetOut_n(resetOut_n), .resetOe(resetOe),
      .oscRun(oscRun), .standby(standby), .charge(charge));
   scrc_bus_master i_scrc_bus_master (.scl(sclIn), .sdaDrv(sdaDrv), .sdaWire(sdaIn));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   initial begin
      oscClkIn = 1'b0;
      forever #15259 oscClkIn = ~oscClkIn;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick

   function automatic logic [31:0] rnd();
      rndState ^= rndState << 13;
      rndState ^= rndState >> 17;
      rndState ^= rndState << 5;
      return rndState;
   endfunction : rnd

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk

   task automatic stop_test();
      $display("Compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test

   // p below zero skips the pointer byte
   task automatic xact(input logic [6:0] a, input logic rd, input logic ok, input int p,
      input int n);
      logic [7:0] d;
      i_scrc_bus_master.busStart();
      i_scrc_bus_master.wrByte({a, rd}, ack);
      chk("addrAck", ack, ok);
      if (ack && !rd && p >= 0) begin
         i_scrc_bus_master.wrByte(p[7:0], ack);
         chk("ptrAck", ack, 1'b1);
         ptr = p;
      end
      for (int i = 0; ack && i < n; i++) begin
         if (rd) begin
            i_scrc_bus_master.rdByte(i == n - 1, d);
            chk("rdByte", d, mdl[ptr]);
         end else begin
            d = wq.pop_front();
            i_scrc_bus_master.wrByte(d, ack);
            chk("wrAck", ack, 1'b1);
            mdl[ptr] = (ptr == 4) ? (d & 8'h80) : d;
         end
         ptr = (ptr == 5) ? 0 : ptr + 1;
      end
      i_scrc_bus_master.busStop();
      tick(1);
   endtask : xact

   task automatic holdWait(input int exp);
      int n;
      n = 0;
      while (resetOe !== 1'b0 && n < exp + 50) begin
         tick(1);
         n++;
      end
      chk("holdLen", n >= exp && n <= exp + 6, 1'b1);
   endtask : holdWait

   task automatic powerUp();
      rst_n = 1'b0;
      tick(4);
      rst_n = 1'b1;
      foreach (mdl[i]) mdl[i] = 0;
      ptr = 0;
      chk("charge", charge, 4'h0);
      chk("oscRun", oscRun, 1'b1);
      chk("resetOe", resetOe, 1'b1);
      chk("resetOut_n", resetOut_n, 1'b0);
      chk("standby", standby, 1'b0);
      holdWait(HOLD);
      xact(DEV_ADDR, 1'b1, 1'b1, -1, 6);
   endtask : powerUp

   initial begin
      clkEn = 1'b1;
      supplyLow = 1'b0;
      onBackup = 1'b0;
      powerUp();
      // Eight bytes from 00h run past 05h and wrap onto the low counter bytes
      for (int i = 0; i < 8; i++) wq.push_back((i == 4) ? 8'hFF : 8'(rnd()));
      xact(DEV_ADDR, 1'b0, 1'b1, 0, 8);
      i_scrc_bus_master.qtr = 60;
      xact(DEV_ADDR, 1'b1, 1'b1, -1, 7);
      i_scrc_bus_master.qtr = 20;
      xact(7'h69, 1'b0, 1'b0, -1, 0);
      for (int i = 0; i < 16; i++) begin
         cfg = (i < 12) ? codes[i] : 8'(rnd());
         wq.push_back(cfg);
         xact(DEV_ADDR, 1'b0, 1'b1, 5, 1);
         tick(4);
         en = cfg[7:4] == CHARGER_KEY && cfg[1:0] != RES_NONE &&
            (cfg[3:2] == DIODE_NONE || cfg[3:2] == DIODE_IN);
         chk("chargeEn", charge.enable, en);
         if (en) chk("chargeSel", charge[2:0], {cfg[3:2] == 2'h2, cfg[1:0]});
      end
      onBackup = 1'b1;
      tick(4);
      chk("oscRun", oscRun, 1'b0);
      chk("standby", standby, 1'b1);
      onBackup = 1'b0;
      tick(4);
      chk("oscRun", oscRun, 1'b1);
      wq.push_back(8'h7F);
      xact(DEV_ADDR, 1'b0, 1'b1, 4, 1);
      onBackup = 1'b1;
      tick(4);
      chk("standby", standby, 1'b0);
      chk("oscRun", oscRun, 1'b1);
      onBackup = 1'b0;
      wq.push_back(8'h80);
      xact(DEV_ADDR, 1'b0, 1'b1, 4, 1);
      supplyLow = 1'b1;
      tick(6);
      chk("resetOe", resetOe, 1'b1);
      xact(DEV_ADDR, 1'b0, 1'b0, -1, 0);
      xact(DEV_ADDR, 1'b1, 1'b0, -1, 1);
      supplyLow = 1'b0;
      holdWait(HOLD + START);
      xact(DEV_ADDR, 1'b1, 1'b1, -1, 2);
      powerUp();
      stop_test();
   end

   // The full run needs under a hundred microseconds; this leaves ample margin
   initial begin
      #800000;
      n_fail++;
      stop_test();
   end
endmodule : scrc_core_bench
